//--- design/simc_pkg.sv
// shared constants for the serial link option register block and its host
package simc_pkg;
  // device register addresses on the serial link
  localparam logic [5:0]  SIMC_A_STATUS   = 6'h00;
  localparam logic [5:0]  SIMC_A_MODE     = 6'h01;
  localparam logic [5:0]  SIMC_A_OPTS     = 6'h02;
  localparam logic [5:0]  SIMC_A_CKSUM    = 6'h03;
  localparam logic [5:0]  SIMC_A_RESULT   = 6'h04;
  localparam logic [5:0]  SIMC_A_SETUP    = 6'h20;
  // reset values
  localparam logic [15:0] SIMC_OPTS_RESET  = 16'h0000;
  localparam logic [15:0] SIMC_MODE_RESET  = 16'h2000;
  localparam logic [15:0] SIMC_SETUP_RESET = 16'h0000;
  // serial_link_options fields
  localparam int          SIMC_OPT_ALTERNATE_SYNC_ENABLE = 12;
  localparam int          SIMC_OPT_DRIVE    = 11;
  localparam int          SIMC_OPT_ABSORB   = 10;
  localparam int          SIMC_OPT_HOLD     = 8;
  localparam int          SIMC_OPT_CONTINUOUS_RESULT_READ = 7;
  localparam int          SIMC_OPT_APPEND   = 6;
  localparam int          SIMC_OPT_CHECK    = 5;
  localparam logic [15:0] SIMC_OPTS_WMASK   = 16'h1de0;
  // mode register field that selects continuous conversion
  localparam int          SIMC_MODE_LSB     = 4;
  localparam logic [2:0]  SIMC_MODE_CONT    = 3'h0;
  // command byte
  localparam int          SIMC_CMD_READ     = 6;
  localparam logic [7:0]  SIMC_CMD_EXIT     = 8'h44;
  // status byte fields
  localparam int          SIMC_ST_RDY_N     = 7;
  localparam int          SIMC_ST_REG_ERR   = 6;
  // lengths in bits
  localparam logic [5:0]  SIMC_LEN_8        = 6'h08;
  localparam logic [5:0]  SIMC_LEN_16       = 6'h10;
  localparam logic [5:0]  SIMC_LEN_24       = 6'h18;
  localparam logic [5:0]  SIMC_LEN_32       = 6'h20;
  // host register word addresses
  localparam logic [3:0]  SIMC_H_CMD        = 4'h0;
  localparam logic [3:0]  SIMC_H_WDATA      = 4'h1;
  localparam logic [3:0]  SIMC_H_RDATA      = 4'h2;
  localparam logic [3:0]  SIMC_H_IRQ_STAT   = 4'h3;
  localparam logic [3:0]  SIMC_H_IRQ_MASK   = 4'h4;
  localparam logic [3:0]  SIMC_H_LEVEL      = 4'h5;
  // host command word fields
  localparam int          SIMC_HC_LEN_LSB   = 8;
  localparam int          SIMC_HC_RAW       = 15;
  // host interrupt events
  localparam int          SIMC_EV_DONE      = 0;
  localparam int          SIMC_EV_REFUSED   = 1;
  localparam int          SIMC_EV_W         = 2;
  // reserved option bits as seen in a left-aligned 16-bit write word
  localparam logic [31:0] SIMC_RSV_LEFT     = 32'he2000000;
  localparam int          SIMC_LEFT16       = 16;
  localparam int          SIMC_SCLK_HALF    = 4;
endpackage

//--- design/simc_link_if.sv
// four-wire serial link between host controller and option register device
`timescale 1ns/1ps
interface simc_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // pull-up on the shared data/ready wire while the device lets go
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev
  (
    input  cs_n,
    input  sclk,
    input  mosi,
    output miso_o,
    output miso_oe
  );

  modport host
  (
    output cs_n,
    output sclk,
    output mosi,
    input  miso
  );
endinterface

//--- design/simc_device.sv
// device end: serial link slave with the link option register and checker
`timescale 1ns/1ps
// What this block does
// - 16-bit option register at 0x02, resets zero
// - bits 15..13 and 9 reserved, read-only
// - bit 12 turns sync pin into conversion control
// - bit 11 selects stronger output drive
// - bit 10 low absorbs channel settle delay
// - bit 8 holds last result data bit until deselect
// - host must toggle chip select when hold set
// - bit 7 presents result repeatedly without command
// - host sets continuous conversion before continuous read
// - bit 6 appends status to result reads
// - bit 5 flags any change of user registers
// - clearing bit 5 clears the register error
// - checker skips options, result and status registers
// - host disables checker before changing watched registers
// - checksum register live only while checker enabled
// - appended result read grows to 32 bits
module simc_device
  import simc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  simc_link_if.dev         link,
  input  wire logic [23:0] result,
  input  wire logic [3:0]  result_chan,
  input  wire logic        result_valid,
  output logic             alternate_sync_enable,
  output logic             output_drive_select,
  output logic             settle_delay_absorb,
  output logic [15:0]      mode_out,
  output logic [15:0]      setup_out,
  output logic             reg_error
);

  typedef enum logic [1:0]
  {
    SIMC_S_CMD  = 2'b00,
    SIMC_S_WR   = 2'b01,
    SIMC_S_RD   = 2'b10,
    SIMC_S_DONE = 2'b11
  } simc_dstate_t;

  simc_dstate_t state_r;
  logic [2:0]   cs_q_r;
  logic [2:0]   sclk_q_r;
  logic [1:0]   mosi_q_r;
  logic [5:0]   bcnt_r;
  logic [5:0]   len_r;
  logic [5:0]   addr_r;
  logic [31:0]  shin_r;
  logic [31:0]  shout_r;
  logic         last_bit_r;
  logic         miso_r;
  logic [15:0]  opts_r;
  logic [15:0]  mode_r;
  logic [15:0]  setup_r;
  logic [31:0]  snap_r;
  logic         err_r;
  logic         rdy_n_r;
  logic [3:0]   chan_r;
  logic [23:0]  data_r;

  logic         cs_act;
  logic         rise;
  logic         mosi_s;
  logic [7:0]   in_byte;
  logic [31:0]  in_word;
  logic [7:0]   status_byte;
  logic [23:0]  cksum;
  logic         last_bit;
  logic         wr_commit;
  logic         reading_result;
  logic         cont_go;
  logic         miso_nxt;

  // three-stage samplers for select and clock, two-stage for data; only the second and third stages feed logic
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cs_q_r   <= 3'h7;
      sclk_q_r <= 3'h7;
      mosi_q_r <= 2'h0;
    end
    else
    begin
      cs_q_r   <= {cs_q_r[1:0], link.cs_n};
      sclk_q_r <= {sclk_q_r[1:0], link.sclk};
      mosi_q_r <= {mosi_q_r[0], link.mosi};
    end
  end

  assign cs_act      = ~cs_q_r[1];
  assign rise        = sclk_q_r[1] & ~sclk_q_r[2];
  assign mosi_s      = mosi_q_r[1];
  assign in_byte     = {shin_r[6:0], mosi_s};
  assign in_word     = {shin_r[30:0], mosi_s};
  assign status_byte = {rdy_n_r, err_r, 2'h0, chan_r};
  assign cksum       = opts_r[SIMC_OPT_CHECK] ? {8'h00, mode_r ^ setup_r} : 24'h000000;
  assign last_bit    = (bcnt_r == len_r - 6'h01);
  assign wr_commit   = cs_act & rise & (state_r == SIMC_S_WR) & last_bit;
  assign reading_result = (state_r == SIMC_S_RD) & (addr_r == SIMC_A_RESULT);

  // result presented again with no command each time a fresh one is ready
  assign cont_go = opts_r[SIMC_OPT_CONTINUOUS_RESULT_READ] & ~rdy_n_r & cs_act &
                   (((state_r == SIMC_S_CMD) & (bcnt_r == 6'h00)) |
                    ((state_r == SIMC_S_DONE) & ~opts_r[SIMC_OPT_HOLD]));

  function automatic logic [5:0] rd_len(input logic [5:0] a, input logic app);
    unique case (a)
      SIMC_A_STATUS: rd_len = SIMC_LEN_8;
      SIMC_A_CKSUM:  rd_len = SIMC_LEN_24;
      SIMC_A_RESULT: rd_len = app ? SIMC_LEN_32 : SIMC_LEN_24;
      SIMC_A_MODE,
      SIMC_A_OPTS,
      SIMC_A_SETUP:  rd_len = SIMC_LEN_16;
      default:       rd_len = SIMC_LEN_8;
    endcase
  endfunction

  // read value left aligned so the first bit out is bit 31
  function automatic logic [31:0] rd_val(input logic [5:0] a);
    unique case (a)
      SIMC_A_STATUS: rd_val = {status_byte, 24'h000000};
      SIMC_A_MODE:   rd_val = {mode_r, 16'h0000};
      SIMC_A_OPTS:   rd_val = {opts_r, 16'h0000};
      SIMC_A_CKSUM:  rd_val = {cksum, 8'h00};
      SIMC_A_RESULT: rd_val = opts_r[SIMC_OPT_APPEND] ? {data_r, status_byte}
                                                     : {data_r, 8'h00};
      SIMC_A_SETUP:  rd_val = {setup_r, 16'h0000};
      default:       rd_val = 32'h00000000;
    endcase
  endfunction

  // frame sequencing; every frame restarts at the command byte unless continuous read presents the result
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r    <= SIMC_S_CMD;
      bcnt_r     <= 6'h00;
      len_r      <= SIMC_LEN_8;
      addr_r     <= 6'h00;
      shin_r     <= 32'h00000000;
      shout_r    <= 32'h00000000;
      last_bit_r <= 1'b0;
    end
    else if (!cs_act)
    begin
      state_r <= SIMC_S_CMD;
      bcnt_r  <= 6'h00;
    end
    else if (cont_go)
    begin
      state_r <= SIMC_S_RD;
      bcnt_r  <= 6'h00;
      addr_r  <= SIMC_A_RESULT;
      len_r   <= rd_len(SIMC_A_RESULT, opts_r[SIMC_OPT_APPEND]);
      shout_r <= rd_val(SIMC_A_RESULT);
    end
    else if (rise)
    begin
      shin_r <= in_word;
      bcnt_r <= bcnt_r + 6'h01;
      unique case (state_r)
        SIMC_S_CMD:
        begin
          if (bcnt_r == 6'h07)
          begin
            bcnt_r <= 6'h00;
            addr_r <= in_byte[5:0];
            len_r  <= rd_len(in_byte[5:0], opts_r[SIMC_OPT_APPEND]);
            if (in_byte[SIMC_CMD_READ])
            begin
              state_r <= SIMC_S_RD;
              shout_r <= rd_val(in_byte[5:0]);
            end
            else
            begin
              state_r <= SIMC_S_WR;
            end
          end
        end
        SIMC_S_WR:
        begin
          if (last_bit)
          begin
            state_r <= SIMC_S_DONE;
          end
        end
        SIMC_S_RD:
        begin
          shout_r    <= {shout_r[30:0], 1'b0};
          last_bit_r <= shout_r[31];
          if (last_bit)
          begin
            state_r <= SIMC_S_DONE;
          end
        end
        SIMC_S_DONE:
        begin
          bcnt_r <= bcnt_r;
        end
      endcase
    end
  end

  // option register; reserved and out-of-scope bits never store
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      opts_r <= SIMC_OPTS_RESET;
    end
    else if (wr_commit && addr_r == SIMC_A_OPTS)
    begin
      opts_r <= in_word[15:0] & SIMC_OPTS_WMASK;
    end
    else if (cs_act && rise && reading_result && opts_r[SIMC_OPT_CONTINUOUS_RESULT_READ] &&
             bcnt_r == 6'h07 && in_byte == SIMC_CMD_EXIT)
    begin
      opts_r[SIMC_OPT_CONTINUOUS_RESULT_READ] <= 1'b0;
    end
  end

  // watched user registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      mode_r  <= SIMC_MODE_RESET;
      setup_r <= SIMC_SETUP_RESET;
    end
    else if (wr_commit && addr_r == SIMC_A_MODE)
    begin
      mode_r <= in_word[15:0];
    end
    else if (wr_commit && addr_r == SIMC_A_SETUP)
    begin
      setup_r <= in_word[15:0];
    end
  end

  // snapshot follows the watched set while the checker is off; once on it is
  // re-taken after each flagged change, so a change is a one-cycle event and
  // a later clear of the flag sticks
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      snap_r <= {SIMC_MODE_RESET, SIMC_SETUP_RESET};
    end
    else if (!opts_r[SIMC_OPT_CHECK] || {mode_r, setup_r} != snap_r)
    begin
      snap_r <= {mode_r, setup_r};
    end
  end

  // set is placed after clear so a change seen in the clearing cycle survives
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      err_r <= 1'b0;
    end
    else
    begin
      if (wr_commit && addr_r == SIMC_A_OPTS && !in_word[SIMC_OPT_CHECK])
      begin
        err_r <= 1'b0;
      end
      if (opts_r[SIMC_OPT_CHECK] && {mode_r, setup_r} != snap_r)
      begin
        err_r <= 1'b1;
      end
    end
  end

  // a result arriving while the result is being shifted out is dropped
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdy_n_r <= 1'b1;
      data_r  <= 24'h000000;
      chan_r  <= 4'h0;
    end
    else if (result_valid && !reading_result)
    begin
      rdy_n_r <= 1'b0;
      data_r  <= result;
      chan_r  <= result_chan;
    end
    else if (cs_act && rise && reading_result && last_bit)
    begin
      rdy_n_r <= 1'b1;
    end
  end

  // shared data/ready output: data bit, held last bit, or ready flag
  always_comb
  begin
    if (state_r == SIMC_S_RD)
    begin
      miso_nxt = shout_r[31];
    end
    else if (state_r == SIMC_S_DONE && opts_r[SIMC_OPT_HOLD] && addr_r == SIMC_A_RESULT)
    begin
      miso_nxt = last_bit_r;
    end
    else
    begin
      miso_nxt = rdy_n_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      miso_r <= 1'b1;
    end
    else
    begin
      miso_r <= miso_nxt;
    end
  end

  assign link.miso_o  = miso_r;
  assign link.miso_oe = cs_act;

  // option outputs to the conversion engine and pad ring
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      alternate_sync_enable <= 1'b0;
      output_drive_select   <= 1'b0;
      settle_delay_absorb   <= 1'b0;
      mode_out              <= SIMC_MODE_RESET;
      setup_out             <= SIMC_SETUP_RESET;
      reg_error             <= 1'b0;
    end
    else
    begin
      alternate_sync_enable <= opts_r[SIMC_OPT_ALTERNATE_SYNC_ENABLE];
      output_drive_select   <= opts_r[SIMC_OPT_DRIVE];
      // low means absorb, as the option encodes it
      settle_delay_absorb   <= ~opts_r[SIMC_OPT_ABSORB];
      mode_out              <= mode_r;
      setup_out             <= setup_r;
      reg_error             <= err_r;
    end
  end

endmodule

//--- design/simc_host.sv
// host end: register-driven serial link master for the option register device
`timescale 1ns/1ps
module simc_host
  import simc_pkg::*;
#(
  parameter int SCLK_HALF = SIMC_SCLK_HALF
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  simc_link_if.host        link,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [31:0]      reg_rdata,
  output logic             irq
);

  // device samples through three stages; slower halves keep data settled
  if (SCLK_HALF < 4 || SCLK_HALF > 255)
  begin
    $error("SCLK_HALF out of range");
  end

  typedef enum logic [2:0]
  {
    SIMC_H_IDLE  = 3'b000,
    SIMC_H_LEAD  = 3'b001,
    SIMC_H_SHIFT = 3'b010,
    SIMC_H_TRAIL = 3'b011,
    SIMC_H_GAP   = 3'b100
  } simc_hstate_t;

  simc_hstate_t          state_r;
  logic [7:0]            div_r;
  logic [31:0]           wdata_r;
  logic [39:0]           tx_r;
  logic [31:0]           rx_r;
  logic [5:0]            len_r;
  logic [6:0]            cnt_r;
  logic                  cs_n_r;
  logic                  sclk_r;
  logic                  mosi_r;
  logic [1:0]            miso_q_r;
  logic                  check_sh_r;
  logic [2:0]            mode_sh_r;
  logic [SIMC_EV_W-1:0]  stat_r;
  logic [SIMC_EV_W-1:0]  mask_r;

  logic                  tick;
  logic                  cmd_wr;
  logic [5:0]            c_addr;
  logic                  c_read;
  logic                  c_raw;
  logic [5:0]            c_len;
  logic                  c_write;
  logic                  refuse;
  logic                  accept;
  logic [31:0]           wd;
  logic [SIMC_EV_W-1:0]  ev;

  assign tick    = (state_r != SIMC_H_IDLE) && (div_r == 8'(SCLK_HALF - 1));
  assign cmd_wr  = reg_we && (reg_addr == SIMC_H_CMD);
  assign c_addr  = reg_wdata[5:0];
  assign c_read  = reg_wdata[SIMC_CMD_READ];
  assign c_raw   = reg_wdata[SIMC_HC_RAW];
  assign c_len   = reg_wdata[SIMC_HC_LEN_LSB +: 6];
  assign c_write = !c_read && !c_raw;

  // watched registers may not be written while the checker is on, and
  // continuous read needs continuous conversion selected first
  assign refuse = (state_r != SIMC_H_IDLE) || (c_len == 6'h00) || (c_len > SIMC_LEN_32) ||
                  (c_write && check_sh_r &&
                   (c_addr == SIMC_A_MODE || c_addr == SIMC_A_SETUP)) ||
                  (c_write && c_addr == SIMC_A_OPTS &&
                   wdata_r[SIMC_LEFT16 + SIMC_OPT_CONTINUOUS_RESULT_READ] &&
                   mode_sh_r != SIMC_MODE_CONT);
  assign accept = cmd_wr && !refuse;
  assign wd     = (c_write && c_addr == SIMC_A_OPTS) ? (wdata_r & ~SIMC_RSV_LEFT)
                                                    : wdata_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      miso_q_r <= 2'h3;
    end
    else
    begin
      miso_q_r <= {miso_q_r[0], link.miso};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div_r <= 8'h00;
    end
    else if (state_r == SIMC_H_IDLE || tick)
    begin
      div_r <= 8'h00;
    end
    else
    begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wdata_r <= 32'h00000000;
    end
    else if (reg_we && reg_addr == SIMC_H_WDATA)
    begin
      wdata_r <= reg_wdata;
    end
  end

  // shadows of what this host last wrote to the device
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      check_sh_r <= 1'b0;
      mode_sh_r  <= SIMC_MODE_RESET[SIMC_MODE_LSB +: 3];
    end
    else if (accept && c_write && c_addr == SIMC_A_OPTS)
    begin
      check_sh_r <= wdata_r[SIMC_LEFT16 + SIMC_OPT_CHECK];
    end
    else if (accept && c_write && c_addr == SIMC_A_MODE)
    begin
      mode_sh_r <= wdata_r[SIMC_LEFT16 + SIMC_MODE_LSB +: 3];
    end
  end

  // chip select always framed by this host, never left low
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= SIMC_H_IDLE;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b1;
      mosi_r  <= 1'b0;
      tx_r    <= 40'h0000000000;
      rx_r    <= 32'h00000000;
      cnt_r   <= 7'h00;
      len_r   <= 6'h00;
    end
    else
    begin
      unique case (state_r)
        SIMC_H_IDLE:
        begin
          if (accept)
          begin
            state_r <= SIMC_H_LEAD;
            cs_n_r  <= 1'b0;
            tx_r    <= c_raw ? {wd, 8'h00} : {2'b00, c_addr, wd} | {1'b0, c_read, 38'h0};
            cnt_r   <= c_raw ? {1'b0, c_len} : 7'({1'b0, c_len} + 7'h08);
            len_r   <= c_len;
            rx_r    <= 32'h00000000;
          end
        end
        SIMC_H_LEAD:
        begin
          if (tick)
          begin
            state_r <= SIMC_H_SHIFT;
          end
        end
        SIMC_H_SHIFT:
        begin
          if (tick && sclk_r)
          begin
            sclk_r <= 1'b0;
            mosi_r <= tx_r[39];
            tx_r   <= {tx_r[38:0], 1'b0};
          end
          else if (tick)
          begin
            sclk_r <= 1'b1;
            // command-phase bits are ready flags, so only data bits are kept
            if (cnt_r <= {1'b0, len_r})
            begin
              rx_r <= {rx_r[30:0], miso_q_r[1]};
            end
            cnt_r  <= cnt_r - 7'h01;
            if (cnt_r == 7'h01)
            begin
              state_r <= SIMC_H_TRAIL;
            end
          end
        end
        SIMC_H_TRAIL:
        begin
          if (tick)
          begin
            cs_n_r  <= 1'b1;
            state_r <= SIMC_H_GAP;
          end
        end
        SIMC_H_GAP:
        begin
          if (tick)
          begin
            state_r <= SIMC_H_IDLE;
          end
        end
        default:
        begin
          state_r <= SIMC_H_IDLE;
        end
      endcase
    end
  end

  assign ev[SIMC_EV_DONE]    = (state_r == SIMC_H_GAP) && tick;
  assign ev[SIMC_EV_REFUSED] = cmd_wr && refuse;

  // a read of the status clears it; an event in that cycle still lands
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stat_r <= '0;
      mask_r <= '0;
    end
    else
    begin
      stat_r <= ((reg_re && reg_addr == SIMC_H_IRQ_STAT) ? '0 : stat_r) | ev;
      if (reg_we && reg_addr == SIMC_H_IRQ_MASK)
      begin
        mask_r <= reg_wdata[SIMC_EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_re)
    begin
      unique case (reg_addr)
        SIMC_H_WDATA:    reg_rdata <= wdata_r;
        SIMC_H_RDATA:    reg_rdata <= rx_r;
        SIMC_H_IRQ_STAT: reg_rdata <= {30'h0, stat_r};
        SIMC_H_IRQ_MASK: reg_rdata <= {30'h0, mask_r};
        SIMC_H_LEVEL:    reg_rdata <= {30'h0, miso_q_r[1], state_r != SIMC_H_IDLE};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end
  end

  assign irq       = |(stat_r & mask_r);
  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;

endmodule

//--- verif/simc_link_assertions.sv
// concurrent checks on the serial link wires between host and device
`timescale 1ns/1ps
module simc_link_assertions
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // device takes the wire a few clocks after select falls
  sequence frame_open;
    $fell(cs_n);
  endsequence
  sequence dev_drives;
    ##[1:4] miso_oe;
  endsequence

  oe_on_a: assert property (frame_open |-> dev_drives)
    else $error("device did not drive data line after select");
  oe_off_a: assert property (cs_n [*4] |-> !miso_oe)
    else $error("device still drives data line after deselect");
  pull_up_a: assert property (!miso_oe |-> miso)
    else $error("released data line not high");
  wire_pass_a: assert property (miso_oe |-> miso == miso_o)
    else $error("data line differs from device output");
  half_low_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  sclk_frame_a: assert property (!sclk |-> !cs_n)
    else $error("serial clock low outside a frame");
  mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("host data changed at sampling edge");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select high time between frames too short");
endmodule

//--- verif/serial_interface_mode_config_tb.sv
// self-checking bench for the option register host and device pair
`timescale 1ns/1ps
module serial_interface_mode_config_tb;
  import simc_pkg::*;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'h0;
  logic        reg_re = 1'h0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [23:0] result = 24'h0;
  logic [3:0]  result_chan = 4'h0;
  logic        result_valid = 1'h0;
  logic        alt;
  logic        drv;
  logic        absorb;
  logic        reg_error;
  logic [31:0] r;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;

  simc_link_if lnk();
  simc_host i_simc_host (.clk(clk), .resetn(resetn), .link(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));
  simc_device i_simc_device (.clk(clk), .resetn(resetn), .link(lnk), .result(result),
    .result_chan(result_chan), .result_valid(result_valid), .alternate_sync_enable(alt),
    .output_drive_select(drv), .settle_delay_absorb(absorb), .mode_out(), .setup_out(),
    .reg_error(reg_error));
  simc_link_assertions i_simc_link_assertions (.clk(clk), .resetn(resetn), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe),
    .miso(lnk.miso));

  always #10 clk = ~clk;

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // the whole test is far below this, so only a hang reaches it
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'h1;
    @(posedge clk);
    reg_we <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'h1;
    @(posedge clk);
    reg_re <= 1'h0;
    #1 d = reg_rdata;
  endtask

  // one link frame: data word, command word, wait for done, clear, fetch
  task automatic t(input logic [15:0] cmd, input logic [31:0] wd, output logic [31:0] d);
    int          n;
    logic [31:0] s;
    n = 0;
    wr(SIMC_H_WDATA, wd);
    wr(SIMC_H_CMD, {16'h0, cmd});
    while (irq !== 1'h1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    rd(SIMC_H_IRQ_STAT, s);
    chk(s, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(SIMC_H_RDATA, d);
  endtask

  task automatic pr(input logic [23:0] d, input logic [3:0] c);
    @(posedge clk);
    result <= d;
    result_chan <= c;
    result_valid <= 1'h1;
    @(posedge clk);
    result_valid <= 1'h0;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    wr(SIMC_H_IRQ_MASK, 32'h1);
    t(16'h1042, 32'h0, r);
    chk(r, 32'h0);
    t(16'h1002, 32'hffff0000, r);
    t(16'h1042, 32'h0, r);
    chk(r, 32'h1de0);
    chk({29'h0, alt, drv, absorb}, 32'h6);
    t(16'h1843, 32'h0, r);
    chk(r, 32'h2000);
    pr(24'h123456, 4'h3);
    t(16'ha000, 32'h0, r);
    chk(r, 32'h12345603);
    t(16'h1002, 32'h00600000, r);
    chk({31'h0, reg_error}, 32'h0);
    pr(24'habcdef, 4'h5);
    t(16'h2044, 32'h0, r);
    chk(r, 32'habcdef05);
    t(16'h9800, 32'h01201000, r);
    chk({31'h0, reg_error}, 32'h1);
    t(16'h0840, 32'h0, r);
    chk({31'h0, r[SIMC_ST_REG_ERR]}, 32'h1);
    wr(SIMC_H_WDATA, 32'h20100000);
    wr(SIMC_H_CMD, 32'h1001);
    rd(SIMC_H_IRQ_STAT, r);
    chk(r, 32'h2);
    t(16'h1002, 32'h00400000, r);
    chk({31'h0, reg_error}, 32'h0);
    t(16'h1843, 32'h0, r);
    chk(r, 32'h0);
    t(16'h1001, 32'h00100000, r);
    wr(SIMC_H_WDATA, 32'h00800000);
    wr(SIMC_H_CMD, 32'h1002);
    rd(SIMC_H_IRQ_STAT, r);
    chk(r, 32'h2);
    end_of_test();
  end
endmodule
